//--- hdl/port_bc_top.sv
// Second port and high-voltage port routing, contact sense and APB registers
//
// Function
// - Second port data at index 1, direction at 5; reset clears direction only.
// - High-voltage data at index 2, direction at 6; reset turns lines off.
// - High-voltage direction one means output, or sense mode with sense enable.
// - Capture-XOR enable feeds capture channel one with XOR of two pins.
// - Bit 5 of second port data read returns capture channel one.
// - Line-4 PWM enable routes PWM to line 4, driven only with direction.
// - Line-3 compare enable routes compare two to line 3 with direction.
// - Line-2 capture select picks second or high-voltage line 2 for capture two.
// - Line-1 compare enable routes compare one to line 1 with direction.
// - Line-0 capture select picks second port line 0 or high-voltage line 0/4.
// - Amplifier enable is routing config bit 6; it feeds converter channel 4.
// - High-voltage lines 5 and 6 are open-drain only: sink or off.
// - Line 0 senses to supply, line 4 to ground, lines 1-3 by data bit.
// - Sense status bits 4-0 read one when outside resistance is low.
// - Sense enabled with direction clear: status is one for low input voltage.
// - Any enabled status bit change, either edge, sets the change flag.
// - Interrupt request only with interrupt enable; flag records regardless.
// - Diagnostic link mode: line 4 output plus mode bit; output enables bias.
// - Writing one clears the change flag; writing zero does nothing.
`default_nettype none
module port_bc_top
  import port_bc_pkg::*;
#(
  parameter int SP_W = 5,
  parameter int HV_W = 7,
  parameter int CS_W = 5
) (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst_b,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output var  logic [31:0]               prdata,
  output var  logic                      pready,
  output var  logic                      pslverr,
  // Second port pins
  input  wire logic [SP_W-1:0]           sp_in,
  output var  logic [SP_W-1:0]           sp_out,
  output var  logic [SP_W-1:0]           sp_oe,
  // High-voltage port pins and sense front end
  input  wire logic [HV_W-1:0]           hv_in,
  input  wire logic [CS_W-1:0]           sense_in,
  output var  logic [HV_W-1:0]           hv_out,
  output var  logic [HV_W-1:0]           hv_oe,
  output var  logic [CS_W-1:0]           sense_active,
  output var  logic [CS_W-1:0]           sense_to_supply,
  output var  logic                      diag_bias_en,
  output var  logic                      diag_link_out,
  // Timer, PWM and analog side
  input  wire logic                      compare_one,
  input  wire logic                      compare_two,
  input  wire logic                      pwm_in,
  output var  port_bc_pkg::capture_bus_t capture,
  output var  logic                      amp_enable,
  output var  logic                      sense_irq
);
  import port_bc_pkg::*;

  // ==========================================================================
  // Register state
  logic [SP_W-1:0]    sp_data_reg;
  logic [SP_W-1:0]    sp_dir_reg;
  logic [HV_W-1:0]    hv_data_reg;
  logic [HV_W-1:0]    hv_dir_reg;
  io_routing_config_t route_cfg_reg;
  logic [CS_W-1:0]    sense_en_reg;
  logic               irq_en_reg;
  logic               diag_mode_reg;
  logic               cap1_hv4_reg;
  logic [CS_W-1:0]    status_reg;
  logic [CS_W-1:0]    status_next;
  logic [CS_W-1:0]    status_prev_reg;
  logic               flag_reg;
  apb_state_t         apb_state_reg;

  logic               wr_en;
  logic               mapped;
  logic               cap1_hv;
  logic               cap1_next;
  logic               cap2_next;
  logic               change_seen;
  logic [31:0]        rdata_next;

  // ==========================================================================
  // APB slave: one wait state, answer comes from flip-flops
  assign wr_en = psel && penable && pwrite && pready;

  always_comb begin
    mapped = 1'b1;
    rdata_next = 32'h0000_0000;
    case (paddr)
      SP_DATA_ADDR: begin
        rdata_next[SP_W-1:0] = (sp_dir_reg & sp_data_reg) | (~sp_dir_reg & sp_in);
        rdata_next[CAP1_POLL_BIT] = capture.capture_one;
      end
      HV_DATA_ADDR: begin
        rdata_next[HV_W-1:0] = (hv_dir_reg & hv_data_reg) | (~hv_dir_reg & hv_in);
      end
      SP_DIR_ADDR:  rdata_next[SP_W-1:0] = sp_dir_reg;
      HV_DIR_ADDR:  rdata_next[HV_W-1:0] = hv_dir_reg;
      ROUTE_ADDR:   rdata_next[7:0] = route_cfg_reg;
      SENSE_EN_ADDR: begin
        rdata_next[CS_W-1:0] = sense_en_reg;
        rdata_next[IRQ_EN_BIT] = irq_en_reg;
      end
      SENSE_ST_ADDR: begin
        rdata_next[CS_W-1:0] = status_reg;
        rdata_next[FLAG_BIT] = flag_reg;
      end
      HV_CFG_ADDR: begin
        rdata_next[DIAG_BIT] = diag_mode_reg;
        rdata_next[CAP1_HV4_BIT] = cap1_hv4_reg;
      end
      default: mapped = 1'b0;
    endcase
  end

  // Handshake: ready rises one cycle into the access phase, then drops
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      apb_state_reg <= APB_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      case (apb_state_reg)
        APB_IDLE: begin
          if (psel && penable) begin
            apb_state_reg <= APB_ANS;
            pready <= 1'b1;
            pslverr <= ~mapped;
            prdata <= pwrite ? 32'h0000_0000 : rdata_next;
          end
        end
        APB_ANS: begin
          apb_state_reg <= APB_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
        default: apb_state_reg <= APB_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Data latches keep their value through reset
  always_ff @(posedge mclk) begin
    if (wr_en && paddr == SP_DATA_ADDR) begin
      sp_data_reg <= pwdata[SP_W-1:0];
    end
    if (wr_en && paddr == HV_DATA_ADDR) begin
      hv_data_reg <= pwdata[HV_W-1:0];
    end
  end

  // Direction and configuration registers
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sp_dir_reg <= DIR_RST[SP_W-1:0];
      hv_dir_reg <= DIR_RST[HV_W-1:0];
      route_cfg_reg <= CFG_RST;
      sense_en_reg <= CFG_RST[CS_W-1:0];
      irq_en_reg <= 1'b0;
      diag_mode_reg <= 1'b0;
      cap1_hv4_reg <= 1'b0;
    end else if (wr_en) begin
      case (paddr)
        SP_DIR_ADDR: sp_dir_reg <= pwdata[SP_W-1:0];
        HV_DIR_ADDR: hv_dir_reg <= pwdata[HV_W-1:0];
        ROUTE_ADDR:  route_cfg_reg <= pwdata[7:0];
        SENSE_EN_ADDR: begin
          sense_en_reg <= pwdata[CS_W-1:0];
          irq_en_reg <= pwdata[IRQ_EN_BIT];
        end
        HV_CFG_ADDR: begin
          diag_mode_reg <= pwdata[DIAG_BIT];
          cap1_hv4_reg <= pwdata[CAP1_HV4_BIT];
        end
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Capture routing toward the timer
  assign cap1_hv = cap1_hv4_reg ? hv_in[4] : hv_in[0];
  // XOR path combines both candidate pins; otherwise a plain select
  assign cap1_next = route_cfg_reg.capture_xor_enable ? (sp_in[0] ^ cap1_hv)
                   : (route_cfg_reg.line0_capture_select ? sp_in[0] : cap1_hv);
  assign cap2_next = route_cfg_reg.line2_capture_select ? sp_in[2] : hv_in[2];

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      capture <= '0;
      amp_enable <= 1'b0;
    end else begin
      capture.capture_one <= cap1_next;
      capture.capture_two <= cap2_next;
      amp_enable <= route_cfg_reg.amp_enable;
    end
  end

  // ==========================================================================
  // Second port output drivers; direction gates every alternate function
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sp_out <= '0;
      sp_oe <= '0;
    end else begin
      sp_oe <= sp_dir_reg;
      sp_out <= sp_data_reg;
      sp_out[1] <= route_cfg_reg.line1_compare_enable ? compare_one : sp_data_reg[1];
      sp_out[3] <= route_cfg_reg.line3_compare_enable ? compare_two : sp_data_reg[3];
      sp_out[4] <= route_cfg_reg.line4_pwm_enable ? pwm_in : sp_data_reg[4];
    end
  end

  // ==========================================================================
  // High-voltage port drivers; sense mode takes the line away from the driver
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      hv_out <= '0;
      hv_oe <= '0;
      sense_active <= '0;
      diag_bias_en <= 1'b0;
      diag_link_out <= 1'b0;
    end else begin
      hv_out[CS_W-1:0] <= hv_data_reg[CS_W-1:0];
      hv_oe[CS_W-1:0] <= hv_dir_reg[CS_W-1:0] & ~sense_en_reg;
      sense_active <= hv_dir_reg[CS_W-1:0] & sense_en_reg;
      // Lines 5 and 6 only ever pull low, never drive high
      hv_out[HV_W-1:CS_W] <= '0;
      hv_oe[HV_W-1:CS_W] <= hv_dir_reg[HV_W-1:CS_W] & hv_data_reg[HV_W-1:CS_W];
      // Making line 4 an output is what turns on the link driver bias
      diag_bias_en <= hv_dir_reg[4];
      diag_link_out <= diag_mode_reg & hv_dir_reg[4];
      if (diag_mode_reg) begin
        hv_out[4] <= 1'b0;
        hv_oe[4] <= hv_dir_reg[4] & ~hv_data_reg[4] & ~sense_en_reg[4];
      end
    end
  end

  // Sense polarity: line 0 fixed to supply, line 4 fixed to ground
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sense_to_supply <= '0;
    end else begin
      sense_to_supply[0] <= 1'b1;
      sense_to_supply[3:1] <= ~hv_data_reg[3:1];
      sense_to_supply[4] <= 1'b0;
    end
  end

  // ==========================================================================
  // Status source per line: sense front end, or inverted input level
  for (genvar i = 0; i < CS_W; i++) begin : g_status
    assign status_next[i] = hv_dir_reg[i] ? sense_in[i]
                          : ~hv_in[i];
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      status_reg <= '0;
      status_prev_reg <= '0;
    end else begin
      status_reg <= status_next;
      status_prev_reg <= status_reg;
    end
  end

  // Only lines with sense enabled can raise the flag
  assign change_seen = |((status_reg ^ status_prev_reg) & sense_en_reg);

  // A change in the clearing cycle wins, so no event is lost
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      flag_reg <= 1'b0;
    end else if (change_seen) begin
      flag_reg <= 1'b1;
    end else if (wr_en && paddr == SENSE_ST_ADDR && pwdata[FLAG_BIT]) begin
      flag_reg <= 1'b0;
    end
  end

  // Request is masked; the flag itself is not
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sense_irq <= 1'b0;
    end else begin
      sense_irq <= flag_reg & irq_en_reg;
    end
  end

  // ==========================================================================
  // Checks
  sequence s_access;
    psel && penable && !pready;
  endsequence

  sequence s_answer;
    pready ##1 !pready;
  endsequence

  apb_answer_a: assert property (@(posedge mclk) disable iff (!rst_b)
    s_access |=> s_answer)
    else $error("APB answer not one cycle after access");

  dir_reset_a: assert property (@(posedge mclk) !rst_b |=>
    sp_dir_reg == '0 && hv_dir_reg == '0)
    else $error("Direction not cleared by reset");

  hv_off_a: assert property (@(posedge mclk) !rst_b ##1 !rst_b |->
    hv_oe == '0)
    else $error("High-voltage line driven during reset");

  cap_xor_a: assert property (@(posedge mclk) disable iff (!rst_b)
    route_cfg_reg.capture_xor_enable |=>
      capture.capture_one == ($past(sp_in[0]) ^ $past(cap1_hv)))
    else $error("Capture one not XOR of pins");

  cap1_sel_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !route_cfg_reg.capture_xor_enable && route_cfg_reg.line0_capture_select |=>
      capture.capture_one == $past(sp_in[0]))
    else $error("Capture one not from second port line 0");

  cap1_poll_a: assert property (@(posedge mclk) disable iff (!rst_b)
    psel && penable && !pready && paddr == SP_DATA_ADDR && !pwrite |=>
      prdata[CAP1_POLL_BIT] == $past(capture.capture_one))
    else $error("Capture one not visible in data read");

  pwm_route_a: assert property (@(posedge mclk) disable iff (!rst_b)
    route_cfg_reg.line4_pwm_enable && sp_dir_reg[4] |=> sp_oe[4] && sp_out[4] == $past(pwm_in))
    else $error("PWM not on line 4");

  cmp_route_a: assert property (@(posedge mclk) disable iff (!rst_b)
    route_cfg_reg.line3_compare_enable |=> sp_out[3] == $past(compare_two))
    else $error("Compare two not on line 3");

  cap2_sel_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !route_cfg_reg.line2_capture_select |=> capture.capture_two == $past(hv_in[2]))
    else $error("Capture two source wrong");

  hv_drive_a: assert property (@(posedge mclk) disable iff (!rst_b)
    hv_dir_reg[0] && !sense_en_reg[0] |=> hv_oe[0] && !sense_active[0])
    else $error("High-voltage output line not driven");

  diag_sink_a: assert property (@(posedge mclk) disable iff (!rst_b)
    diag_mode_reg |=> !hv_out[4])
    else $error("Link line driven high");

  flag_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_en && paddr == SENSE_ST_ADDR && pwdata[FLAG_BIT] && !change_seen |=> !flag_reg)
    else $error("Change flag not cleared by write of one");

  open_drain_a: assert property (@(posedge mclk) disable iff (!rst_b)
    hv_out[HV_W-1:CS_W] == '0)
    else $error("Open-drain line driven high");

  flag_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
    change_seen |=> flag_reg)
    else $error("Sense change lost");

  flag_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    flag_reg && !change_seen && !(wr_en && paddr == SENSE_ST_ADDR) |=> flag_reg)
    else $error("Change flag dropped without clear");

  irq_mask_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !irq_en_reg ##1 !irq_en_reg |-> !sense_irq)
    else $error("Sense interrupt not masked");

endmodule : port_bc_top
`default_nettype wire

//--- hdl/port_bc_pkg.sv
// Package with register map, field positions and carriers of the port block
`default_nettype none
package port_bc_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [5:0] SP_DATA_IDX  = 6'h01;
  localparam logic [5:0] HV_DATA_IDX  = 6'h02;
  localparam logic [5:0] SP_DIR_IDX   = 6'h05;
  localparam logic [5:0] HV_DIR_IDX   = 6'h06;
  localparam logic [5:0] ROUTE_IDX    = 6'h10;
  localparam logic [5:0] SENSE_EN_IDX = 6'h11;
  localparam logic [5:0] SENSE_ST_IDX = 6'h12;
  localparam logic [5:0] HV_CFG_IDX   = 6'h13;

  localparam logic [7:0] SP_DATA_ADDR  = {SP_DATA_IDX, 2'h0};
  localparam logic [7:0] HV_DATA_ADDR  = {HV_DATA_IDX, 2'h0};
  localparam logic [7:0] SP_DIR_ADDR   = {SP_DIR_IDX, 2'h0};
  localparam logic [7:0] HV_DIR_ADDR   = {HV_DIR_IDX, 2'h0};
  localparam logic [7:0] ROUTE_ADDR    = {ROUTE_IDX, 2'h0};
  localparam logic [7:0] SENSE_EN_ADDR = {SENSE_EN_IDX, 2'h0};
  localparam logic [7:0] SENSE_ST_ADDR = {SENSE_ST_IDX, 2'h0};
  localparam logic [7:0] HV_CFG_ADDR   = {HV_CFG_IDX, 2'h0};

  // ==========================================================================
  // Field positions
  localparam int CAP1_POLL_BIT = 5;  // Second port data read bit
  localparam int IRQ_EN_BIT    = 7;  // Sense enable register
  localparam int FLAG_BIT      = 7;  // Sense status register
  localparam int DIAG_BIT      = 7;  // High-voltage config register
  localparam int CAP1_HV4_BIT  = 0;  // High-voltage config register

  // Reset values
  localparam logic [7:0] DIR_RST   = 8'h00;
  localparam logic [7:0] CFG_RST   = 8'h00;

  // ==========================================================================
  // Routing configuration fields
  typedef struct packed {
    logic capture_xor_enable;    // bit 7
    logic amp_enable;            // bit 6
    logic spare;                 // bit 5
    logic line4_pwm_enable;      // bit 4
    logic line3_compare_enable;  // bit 3
    logic line2_capture_select;  // bit 2
    logic line1_compare_enable;  // bit 1
    logic line0_capture_select;  // bit 0
  } io_routing_config_t;

  // Timer-side signals gathered together
  typedef struct packed {
    logic capture_one;
    logic capture_two;
  } capture_bus_t;

  // APB slave states
  typedef enum logic [0:0] {
    APB_IDLE = 1'b0,
    APB_ANS  = 1'b1
  } apb_state_t;

endpackage : port_bc_pkg
`default_nettype wire

//--- tb/far_side_model.sv
// Model of the timer, PWM unit, pin loads and switch contacts beside the port block
`default_nettype none
module far_side_model (
  // Pin drive from the block
  input  wire logic [4:0] sp_out,
  input  wire logic [4:0] sp_oe,
  input  wire logic [6:0] hv_out,
  input  wire logic [6:0] hv_oe,
  // Outside levels chosen by the bench
  input  wire logic [4:0] ext_sp,
  input  wire logic [6:0] ext_hv,
  input  wire logic [4:0] closed,
  input  wire logic [2:0] tmr,
  // Levels seen by the block
  output var  logic [4:0] sp_in,
  output var  logic [6:0] hv_in,
  output var  logic [4:0] sense_in,
  output var  logic       compare_one,
  output var  logic       compare_two,
  output var  logic       pwm_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Pin levels
  // A driven line shows its drive; an undriven one shows the outside load
  assign sp_in = (sp_oe & sp_out) | (~sp_oe & ext_sp);
  // No pull-up on the sink lines, so an off line shows only the load
  assign hv_in = (hv_oe & hv_out) | (~hv_oe & ext_hv);
  // A closed contact is a resistance below threshold and reads as one
  assign sense_in = closed;
  // Timer and PWM levels
  assign {compare_one, compare_two, pwm_in} = tmr;
endmodule : far_side_model
`default_nettype wire

//--- tb/tb_port_bc_top.sv
// Self-checking bench for the port routing and contact sense block
`default_nettype none
module tb_port_bc_top
  import port_bc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         mclk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]   paddr = 8'h00, rng = 8'h4E, cfg, d, dir;
  logic [31:0]  pwdata = 32'h0, prdata, q;
  logic         pready, pslverr, err, diag_bias_en, diag_link_out, amp_enable, sense_irq;
  logic         compare_one, compare_two, pwm_in;
  logic [2:0]   tmr = 3'h0;
  logic [4:0]   sp_in, sp_out, sp_oe, ext_sp = 5'h00, closed = 5'h00;
  logic [4:0]   sense_in, sense_active, sense_to_supply;
  logic [6:0]   hv_in, hv_out, hv_oe, ext_hv = 7'h00;
  logic [1:0]   ec;
  capture_bus_t capture;
  int           miscompares = 0, comparisons = 0;
  logic [7:0]   rst_addr [5] = '{SP_DIR_ADDR, HV_DIR_ADDR, ROUTE_ADDR, SENSE_EN_ADDR, HV_CFG_ADDR};

  // ==========================================================================
  // Clock, design and far side
  always #25 mclk = ~mclk;
  port_bc_top uut (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sp_in(sp_in), .sp_out(sp_out), .sp_oe(sp_oe), .hv_in(hv_in), .sense_in(sense_in),
    .hv_out(hv_out), .hv_oe(hv_oe), .sense_active(sense_active),
    .sense_to_supply(sense_to_supply), .diag_bias_en(diag_bias_en),
    .diag_link_out(diag_link_out), .compare_one(compare_one), .compare_two(compare_two),
    .pwm_in(pwm_in), .capture(capture), .amp_enable(amp_enable), .sense_irq(sense_irq));
  far_side_model far (.sp_out(sp_out), .sp_oe(sp_oe), .hv_out(hv_out), .hv_oe(hv_oe),
    .ext_sp(ext_sp), .ext_hv(ext_hv), .closed(closed), .tmr(tmr), .sp_in(sp_in),
    .hv_in(hv_in), .sense_in(sense_in), .compare_one(compare_one),
    .compare_two(compare_two), .pwm_in(pwm_in));

  // ==========================================================================
  // Helpers
  function logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // Second port drive: routed functions replace the data latch per line
  function logic [4:0] exp_sp(input logic [7:0] c, input logic [4:0] dt, input logic [2:0] t);
    logic [4:0] r;
    r = dt;
    if (c[1]) r[1] = t[2];
    if (c[3]) r[3] = t[1];
    if (c[4]) r[4] = t[0];
    return r;
  endfunction : exp_sp
  // Capture sources; the XOR path overrides the line-0 select
  function logic [1:0] exp_cap(input logic [7:0] c, input logic hs, input logic [4:0] s,
                               input logic [6:0] h);
    logic one;
    one = hs ? h[4] : h[0];
    if (c[7]) one = s[0] ^ one;
    else if (c[0]) one = s[0];
    return {one, c[2] ? s[2] : h[2]};
  endfunction : exp_cap
  task automatic fail_now(input string msg);
    miscompares++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask : fail_now
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) fail_now($sformatf("bus read %h expected %h", got, exp));
  endtask : chk_word
  task automatic chk_pins(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) fail_now($sformatf("pins %h expected %h", got, exp));
  endtask : chk_pins
  // One APB transfer; the answer is awaited, never assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt,
                     output logic [31:0] rq, output logic re);
    int n;
    n = 0;
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= dt;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rq = prdata;
    re = pslverr;
    if (n >= 20) fail_now("no ready");
    psel <= 1'h0; penable <= 1'h0;
    @(posedge mclk);
  endtask : apb
  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // ==========================================================================
  // Watchdog, far longer than the whole sequence
  initial begin
    repeat (20000) @(posedge mclk);
    fail_now("timeout");
    wrap_up();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    rst_b <= 1'h1;
    @(posedge mclk);
    // Reset state of control registers and pin enables
    foreach (rst_addr[k]) begin
      apb(1'h0, rst_addr[k], 32'h0, q, err);
      chk_word(q, 32'h0);
    end
    chk_pins({1'h0, hv_oe | {2'h0, sp_oe}}, 8'h00);
    apb(1'h0, 8'hFC, 32'h0, q, err);
    chk_word({31'h0, err}, 32'h1);
    // Routing, corner configurations first, then random ones
    for (int i = 0; i < 14; i++) begin
      rng = lfsr(rng);
      cfg = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : rng;
      rng = lfsr(rng);
      d = rng;
      rng = lfsr(rng);
      dir = rng & 8'h1A;  // Lines 0 and 2 stay inputs so capture sees the outside
      // The first port lives outside this block, so amp enable needs no preparation
      apb(1'h1, ROUTE_ADDR, {24'h0, cfg}, q, err);
      apb(1'h1, SP_DATA_ADDR, {24'h0, d}, q, err);
      apb(1'h1, SP_DIR_ADDR, {24'h0, dir}, q, err);
      apb(1'h1, HV_CFG_ADDR, {31'h0, d[7]}, q, err);
      rng = lfsr(rng);
      ext_sp <= rng[4:0]; ext_hv <= {rng[1:0], rng[7:3]}; tmr <= rng[7:5];
      repeat (3) @(posedge mclk);
      ec = exp_cap(cfg, d[7], ext_sp, ext_hv);
      chk_pins({3'h0, sp_out & sp_oe}, {3'h0, exp_sp(cfg, d[4:0], tmr) & dir[4:0]});
      chk_pins({6'h0, capture}, {6'h0, ec});
      chk_pins({7'h0, amp_enable}, {7'h0, cfg[6]});
      apb(1'h0, SP_DATA_ADDR, 32'h0, q, err);
      chk_word(q & {26'h0, 1'h1, dir[4:0]}, {26'h0, ec[1], d[4:0] & dir[4:0]});
      apb(1'h0, ROUTE_ADDR, 32'h0, q, err);
      chk_word(q, {24'h0, cfg});
    end
    apb(1'h1, ROUTE_ADDR, 32'h0, q, err);
    // Contact sense: lines 1-3 against ground, line 5 sinking, line 6 off
    apb(1'h1, HV_DATA_ADDR, 32'h2E, q, err);
    apb(1'h1, HV_DIR_ADDR, 32'h7F, q, err);
    // Before sense is enabled the lines are plain outputs
    @(posedge mclk);
    chk_pins({1'h0, hv_oe}, 8'h3F);
    chk_pins({1'h0, hv_out & 7'h1F}, 8'h0E);
    apb(1'h1, SENSE_EN_ADDR, 32'h1F, q, err);
    repeat (4) @(posedge mclk);
    apb(1'h1, SENSE_ST_ADDR, 32'h80, q, err);
    chk_pins({3'h0, sense_active}, 8'h1F);
    chk_pins({3'h0, sense_to_supply}, 8'h01);
    chk_pins({1'h0, hv_oe}, 8'h20);
    chk_pins({1'h0, hv_out & 7'h60}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, SENSE_EN_ADDR, {24'h0, i[0], 7'h1F}, q, err);
      rng = lfsr(rng);
      closed <= closed ^ (rng[4:0] | 5'h01);
      repeat (4) @(posedge mclk);
      apb(1'h1, SENSE_ST_ADDR, 32'h0, q, err);  // Writing zero must leave the flag
      apb(1'h0, SENSE_ST_ADDR, 32'h0, q, err);
      chk_word(q & 32'h9F, {24'h0, 1'h1, 2'h0, closed});
      chk_pins({7'h0, sense_irq}, {7'h0, i[0]});
      apb(1'h1, SENSE_ST_ADDR, 32'h80, q, err);
      apb(1'h0, SENSE_ST_ADDR, 32'h0, q, err);
      chk_word(q & 32'h80, 32'h0);
      chk_pins({7'h0, sense_irq}, 8'h00);
    end
    // Sense enabled with direction clear reads the inverted input level
    apb(1'h1, HV_DIR_ADDR, 32'h60, q, err);
    rng = lfsr(rng);
    ext_hv <= rng[6:0];
    repeat (4) @(posedge mclk);
    apb(1'h0, SENSE_ST_ADDR, 32'h0, q, err);
    chk_word(q & 32'h1F, {27'h0, ~ext_hv[4:0]});
    // Diagnostic link needs both the mode bit and line 4 as output
    apb(1'h1, HV_CFG_ADDR, 32'h80, q, err);
    for (int k = 0; k < 2; k++) begin
      apb(1'h1, HV_DIR_ADDR, {27'h0, k[0], 4'h0}, q, err);
      repeat (2) @(posedge mclk);
      chk_pins({6'h0, diag_bias_en, diag_link_out}, {6'h0, k[0], k[0]});
    end
    wrap_up();
  end
endmodule : tb_port_bc_top
`default_nettype wire
